//--- logic/asc_pkg.sv
// Package for the async SRAM host controller: pin carrier, timing counts.
// Assumes a single 25 MHz clock driving all controller logic.
package asc_pkg;
	localparam int ASC_AW         = 19;
	localparam int ASC_DW         = 8;
	localparam int ASC_CLK_NS     = 40;
	// Device timing in ns
	localparam int ASC_T_RC_NS    = 70;
	localparam int ASC_T_AA_NS    = 70;
	localparam int ASC_T_WC_NS    = 70;
	localparam int ASC_T_PWE_NS   = 50;
	localparam int ASC_T_SCE_NS   = 60;
	localparam int ASC_T_SD_NS    = 30;
	localparam int ASC_T_HZWE_NS  = 25;
	localparam int ASC_T_HZOE_NS  = 25;
	// Least times round up
	localparam int ASC_RD_CYC_I   = (ASC_T_AA_NS + ASC_CLK_NS - 1) / ASC_CLK_NS;
	localparam int ASC_WR_LOW_NS  = (ASC_T_SCE_NS > ASC_T_PWE_NS) ? ASC_T_SCE_NS : ASC_T_PWE_NS;
	localparam int ASC_WR_CYC_I   = (ASC_WR_LOW_NS + ASC_CLK_NS - 1) / ASC_CLK_NS;
	localparam int ASC_SD_CYC_I   = (ASC_T_SD_NS + ASC_CLK_NS - 1) / ASC_CLK_NS;
	localparam int ASC_TA_CYC_I   = (ASC_T_HZOE_NS + ASC_CLK_NS - 1) / ASC_CLK_NS;
	localparam logic [2:0] ASC_RD_CYC = 3'(ASC_RD_CYC_I);
	localparam logic [2:0] ASC_WR_CYC = 3'(ASC_WR_CYC_I);
	localparam logic [2:0] ASC_TA_CYC = 3'(ASC_TA_CYC_I);
	localparam logic [2:0] ASC_CNT_ONE = 3'h1;

	typedef struct packed {
		logic              chip_select_n;
		logic              write_strobe_n;
		logic              output_gate_n;
		logic [ASC_AW-1:0] word_address;
	} asc_pins_t;

	localparam asc_pins_t ASC_PINS_IDLE = '{chip_select_n: 1'b1, write_strobe_n: 1'b1,
		output_gate_n: 1'b1, word_address: '0};
endpackage

//--- logic/asc_host.sv
// Host-side controller for a 512K x 8 asynchronous static RAM.
// Requests are taken one at a time and each moves a single byte.
// Assumes the RAM pins are wired straight to this module's pin ports and are
// resolved by the surrounding wiring from data_oe; one 25 MHz clock.
`timescale 1ns/100ps
module asc_host
	import asc_pkg::*;
(
	input  wire logic              mclk,
	input  wire logic              arst_n,
	input  wire logic              req_valid,
	input  wire logic              req_write,
	input  wire logic [ASC_AW-1:0] req_addr,
	input  wire logic [ASC_DW-1:0] req_wdata,
	output logic                   req_ready,
	output logic                   rsp_valid,
	output logic      [ASC_DW-1:0] rsp_rdata,
	output asc_pins_t              pins,
	input  wire logic [ASC_DW-1:0] data_in,
	output logic      [ASC_DW-1:0] data_out,
	output logic                   data_oe
);
	typedef enum logic [2:0] {ASC_IDLE, ASC_READ, ASC_WRITE, ASC_WREND, ASC_TURN} asc_state_t;

	asc_state_t        state_q, state_d;
	logic [2:0]        cnt_q, cnt_d;
	asc_pins_t         pins_d;
	logic [ASC_DW-1:0] dout_d;
	logic              oe_d;
	logic              ready_d;
	logic              rvalid_d;
	logic [ASC_DW-1:0] rdata_d;

	wire take        = req_valid && req_ready;
	wire cnt_done    = (cnt_q == ASC_CNT_ONE);
	wire [2:0] cnt_m1 = cnt_q - 3'h1;

	// Backstop for the bus: drivers stay off whenever the gate is low,
	// even if a later state forgets to drop them
	wire       oe_safe  = oe_d && pins_d.output_gate_n;

	// Controls go idle while the address stays put, so no stray location is hit
	function automatic asc_pins_t asc_release(input asc_pins_t cur);
		asc_pins_t rel;
		rel              = ASC_PINS_IDLE;
		rel.word_address = cur.word_address;
		return rel;
	endfunction

	always_comb
	begin
		state_d  = state_q;
		cnt_d    = cnt_q;
		pins_d   = pins;
		dout_d   = data_out;
		oe_d     = data_oe;
		ready_d  = 1'b0;
		rvalid_d = 1'b0;
		rdata_d  = rsp_rdata;
		case (state_q)
			ASC_IDLE:
			begin
				ready_d = 1'b1;
				if (take)
				begin
					ready_d             = 1'b0;
					// Address goes out with select, never after it
					pins_d.word_address = req_addr;
					pins_d.chip_select_n = 1'b0;
					if (req_write)
					begin
						// Gate stays high so the RAM never drives during our write
						pins_d.output_gate_n  = 1'b1;
						pins_d.write_strobe_n = 1'b0;
						dout_d  = req_wdata;
						oe_d    = 1'b1;
						cnt_d   = ASC_WR_CYC;
						state_d = ASC_WRITE;
					end
					else
					begin
						pins_d.write_strobe_n = 1'b1;
						pins_d.output_gate_n  = 1'b0;
						oe_d    = 1'b0;
						cnt_d   = ASC_RD_CYC;
						state_d = ASC_READ;
					end
				end
			end
			ASC_READ:
			begin
				cnt_d = cnt_m1;
				if (cnt_done)
				begin
					// Sample before the address or controls move
					rdata_d  = data_in;
					rvalid_d = 1'b1;
					pins_d   = asc_release(pins);
					cnt_d    = ASC_TA_CYC;
					state_d  = ASC_TURN;
				end
			end
			ASC_WRITE:
			begin
				// Address and data held across the whole overlap
				cnt_d = cnt_m1;
				if (cnt_done)
				begin
					// Strobe and select rise together; data held one more cycle
					pins_d  = asc_release(pins);
					state_d = ASC_WREND;
				end
			end
			ASC_WREND:
			begin
				oe_d    = 1'b0;
				state_d = ASC_IDLE;
				ready_d = 1'b1;
			end
			ASC_TURN:
			begin
				// RAM needs time to release the lines after a read
				cnt_d = cnt_m1;
				if (cnt_done)
				begin
					state_d = ASC_IDLE;
					ready_d = 1'b1;
				end
			end
			default:
			begin
				state_d = ASC_IDLE;
				pins_d  = ASC_PINS_IDLE;
				oe_d    = 1'b0;
			end
		endcase
	end

	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			state_q <= ASC_IDLE;
		else
			state_q <= state_d;
	end

	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			cnt_q <= 3'h0;
		else
			cnt_q <= cnt_d;
	end

	// All controls launch from one register, so they move on the same edge
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			pins <= ASC_PINS_IDLE;
		else
			pins <= pins_d;
	end

	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			data_out <= 8'h00;
		else
			data_out <= dout_d;
	end

	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			data_oe <= 1'b0;
		else
			data_oe <= oe_safe;
	end

	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			req_ready <= 1'b0;
		else
			req_ready <= ready_d;
	end

	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			rsp_valid <= 1'b0;
		else
			rsp_valid <= rvalid_d;
	end

	// Holds the last read byte until the next read completes
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			rsp_rdata <= 8'h00;
		else
			rsp_rdata <= rdata_d;
	end
endmodule

//--- dv/asc_host_asserts.sv
// Pin-side assertions for the async SRAM host controller.
// Bound to asc_host from the bench top; one clock domain.
`timescale 1ns/100ps
module asc_host_asserts
	import asc_pkg::*;
(
	input wire logic              mclk,
	input wire logic              arst_n,
	input wire logic              req_ready,
	input wire asc_pins_t         pins,
	input wire logic [ASC_DW-1:0] data_out,
	input wire logic              data_oe
);
	wire logic sel = !pins.chip_select_n;
	wire logic wr  = !pins.write_strobe_n;
	wire logic rd  = !pins.output_gate_n;
	default clocking @(posedge mclk); endclocking
	default disable iff (!arst_n);
	a_read_strobe_high: assert property ($rose(rd) |-> (sel && !wr && rd)[*2])
		else $error("read access shape wrong");
	a_no_bus_fight: assert property (rd |-> !data_oe)
		else $error("host drives during read");
	a_write_data_hold: assert property ($rose(wr) |-> data_oe ##1 $stable(data_out) ##1 data_oe && $stable(data_out))
		else $error("write data not held");
	a_write_width: assert property ($rose(wr) |-> (wr && sel)[*2] ##1 !wr && !sel)
		else $error("write overlap width wrong");
	a_addr_at_select: assert property ($rose(sel) |=> $stable(pins.word_address))
		else $error("address moved after select");
	a_addr_in_write: assert property (wr && $past(wr) |-> $stable(pins.word_address))
		else $error("address moved in write");
	a_idle_quiet: assert property (req_ready |-> !sel && !data_oe)
		else $error("pins busy while ready");
	cover property ($rose(rd));
	cover property ($rose(wr));
	cover property ($fell(data_oe));
endmodule

//--- dv/asc_sram_model.sv
// Behavioural 512K x 8 async SRAM for the host bench.
// Pins come from the host; the bench resolves the data lines.
`timescale 1ns/100ps
module asc_sram_model
	import asc_pkg::*;
#(
	parameter int ACC_NS = 70
)
(
	input  wire asc_pins_t         pins,
	input  wire logic [ASC_DW-1:0] data_lines,
	output logic      [ASC_DW-1:0] rd_data,
	output logic                   rd_en
);
	logic [ASC_DW-1:0] mem [0:(1<<ASC_AW)-1];
	wire logic wr_now = !pins.chip_select_n && !pins.write_strobe_n;
	// Stores all through the overlap, so the last byte before the end wins
	always @*
		if (wr_now)
			mem[pins.word_address] = data_lines;
	assign rd_en = !pins.chip_select_n && pins.write_strobe_n && !pins.output_gate_n;
	// Worst-case access: an early sample sees the old byte or unknown
	assign #(ACC_NS) rd_data = mem[pins.word_address];
endmodule

//--- dv/asc_host_tb_top.sv
// Self-checking bench for asc_host against the SRAM model.
// Floating data lines show a pattern that flips every cycle.
`timescale 1ns/100ps
module asc_host_tb_top
	import asc_pkg::*;
;
	logic              mclk, arst_n, req_valid, req_write, req_ready, rsp_valid, data_oe, ram_en;
	logic [ASC_AW-1:0] req_addr;
	logic [ASC_DW-1:0] req_wdata, rsp_rdata, data_out, ram_q, bus_q, got;
	asc_pins_t         pins;
	int                bad_count, compares;
	wire logic [ASC_DW-1:0] data_in = data_oe ? data_out : (ram_en ? ram_q : ~bus_q);
	wire logic [ASC_DW-1:0] ctl_seen = {3'h0, req_ready, data_oe, pins.chip_select_n, pins.write_strobe_n,
		pins.output_gate_n};
	asc_host dut (.mclk(mclk), .arst_n(arst_n), .req_valid(req_valid), .req_write(req_write),
		.req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready), .rsp_valid(rsp_valid),
		.rsp_rdata(rsp_rdata), .pins(pins), .data_in(data_in), .data_out(data_out), .data_oe(data_oe));
	asc_sram_model ram (.pins(pins), .data_lines(data_in), .rd_data(ram_q), .rd_en(ram_en));
	always @(posedge mclk)
		bus_q <= data_in;
	initial
	begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end
	task automatic chk(input string nm, input logic [ASC_DW-1:0] exp, input logic [ASC_DW-1:0] seen);
		compares++;
		if (seen !== exp)
		begin
			$display("[ERR] %s exp %h got %h", nm, exp, seen);
			bad_count++;
		end
	endtask
	task automatic xfer(input logic w, input logic [ASC_AW-1:0] a, input logic [ASC_DW-1:0] d);
		int n;
		@(posedge mclk);
		req_valid <= 1'b1;
		req_write <= w;
		req_addr <= a;
		req_wdata <= d;
		n = 0;
		do @(posedge mclk) n++; while (req_ready !== 1'b1 && n < 20);
		chk("req taken", 8'h01, {7'h0, req_ready});
		req_valid <= 1'b0;
		while (!w && rsp_valid !== 1'b1 && n < 40) @(posedge mclk) n++;
		if (!w)
			chk("rsp_valid", 8'h01, {7'h0, rsp_valid});
		got = rsp_rdata;
	endtask
	task automatic t_reset_idle();
		@(negedge mclk);
		chk("idle pins", 8'h17, ctl_seen);
	endtask
	// Walking ones plus both ends catch stuck or aliased address bits
	task automatic t_walk();
		xfer(1'b1, 19'h0, 8'ha5);
		xfer(1'b1, 19'h7ffff, 8'h5a);
		for (int i = 0; i < ASC_AW; i++)
			xfer(1'b1, 19'h1 << i, 8'(i + 1));
		xfer(1'b0, 19'h0, 8'h0);
		chk("rd low end", 8'ha5, got);
		xfer(1'b0, 19'h7ffff, 8'h0);
		chk("rd high end", 8'h5a, got);
		for (int i = 0; i < ASC_AW; i++)
		begin
			xfer(1'b0, 19'h1 << i, 8'h0);
			chk("rd walk", 8'(i + 1), got);
		end
	endtask
	task automatic t_overwrite();
		xfer(1'b1, 19'h12345, 8'h3c);
		xfer(1'b1, 19'h12345, 8'hc3);
		xfer(1'b0, 19'h12345, 8'h0);
		chk("rd overwrite", 8'hc3, got);
		xfer(1'b0, 19'h12345, 8'h0);
		chk("rd repeat", 8'hc3, got);
	endtask
	// Reset in mid-write must drop every control at once
	task automatic t_reset_mid();
		xfer(1'b1, 19'h00abc, 8'h77);
		@(posedge mclk);
		arst_n <= 1'b0;
		@(negedge mclk);
		chk("mid reset pins", 8'h07, ctl_seen);
		repeat (3) @(posedge mclk);
		arst_n <= 1'b1;
		xfer(1'b0, 19'h12345, 8'h00);
		chk("rd after reset", 8'hc3, got);
	endtask
	task automatic final_report();
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial
	begin
		arst_n = 1'b0;
		req_valid = 1'b0;
		req_write = 1'b0;
		req_addr = '0;
		req_wdata = '0;
		repeat (8) @(posedge mclk);
		arst_n <= 1'b1;
		@(posedge mclk);
		t_reset_idle();
		t_walk();
		t_overwrite();
		t_reset_mid();
		final_report();
	end
	initial
	begin
		#400000;
		$display("[ERR] watchdog exp finish got timeout");
		bad_count++;
		final_report();
	end
endmodule
bind asc_host asc_host_asserts chk_i (.mclk(mclk), .arst_n(arst_n), .req_ready(req_ready), .pins(pins),
	.data_out(data_out), .data_oe(data_oe));
